/* core/uic_pkg.sv */
// Constants, field layouts and carrier types for the UART control and IR codec block.
// Assumes one clock, synchronous inputs and an APB master with 32-bit data.
package uic_pkg;

    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_LVL   = 12'h004;
    localparam logic [11:0] OFS_MASK  = 12'h008;
    localparam logic [11:0] OFS_RAW   = 12'h00C;
    localparam logic [11:0] OFS_MSTAT = 12'h010;
    localparam logic [11:0] OFS_CLR   = 12'h014;

    localparam int CTL_EN    = 0;
    localparam int CTL_SIR   = 1;
    localparam int CTL_LP    = 2;
    localparam int CTL_TXE   = 8;
    localparam int CTL_RXE   = 9;

    localparam int IRQ_BITS  = 11;
    localparam int IRQ_OVR   = 10;
    localparam int IRQ_BRK   = 9;
    localparam int IRQ_PAR   = 8;
    localparam int IRQ_FRM   = 7;
    localparam int IRQ_RTO   = 6;
    localparam int IRQ_TXL   = 5;
    localparam int IRQ_RXL   = 4;

    localparam int LVL_RX_LO = 3;
    localparam int LVL_TX_LO = 0;
    localparam logic [2:0] LVL_HALF = 3'h2;

    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W    = 5;
    localparam logic [1:0] PULSE_TICKS = 2'h3;

    typedef struct packed {
        logic receive_section_enable;
        logic transmit_section_enable;
        logic lowPower;
        logic ir_codec_enable;
        logic en;
    } uic_ctrl_type;

    typedef struct packed {
        logic [2:0] rxSel;
        logic [2:0] txSel;
    } uic_level_type;

    typedef enum logic [1:0] {
        ENC_IDLE  = 2'b01,
        ENC_PULSE = 2'b10
    } uic_enc_type;

    // Trigger point in entries for a level code; reserved codes give no trigger.
    function automatic logic [LEVEL_W-1:0] trigPoint(input logic [2:0] code);
        case (code)
            3'h0:    trigPoint = LEVEL_W'(FIFO_DEPTH / 8);
            3'h1:    trigPoint = LEVEL_W'(FIFO_DEPTH / 4);
            3'h2:    trigPoint = LEVEL_W'(FIFO_DEPTH / 2);
            3'h3:    trigPoint = LEVEL_W'(FIFO_DEPTH * 3 / 4);
            3'h4:    trigPoint = LEVEL_W'(FIFO_DEPTH * 7 / 8);
            default: trigPoint = '1;
        endcase
    endfunction

endpackage

/* core/uic_core.sv */
// Control register, IR pulse codec, FIFO level triggers and interrupt masking of a UART.
// Assumes the serializer, FIFOs and error detectors sit outside and drive synchronous inputs.
module uic_core
    import uic_pkg::*;
(
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        txSerialBit,
    input  wire logic                        txBitStart,
    input  wire logic                        baud16Tick,
    input  wire logic                        ir_low_power_ref_clk,
    input  wire logic                        txCharBusy,
    input  wire logic                        rxCharBusy,
    input  wire logic                        wired_rx_line,
    input  wire logic                        ir_pulse_in,
    input  wire logic [3:0]                  modemIn,
    input  wire logic [3:0]                  lineErrEvt,
    input  wire logic                        rxTimeoutEvt,
    input  wire logic [uic_pkg::LEVEL_W-1:0] txFifoLevel,
    input  wire logic [uic_pkg::LEVEL_W-1:0] rxFifoLevel,
    output logic                             ir_pulse_out_n,
    output logic                             wired_tx_line,
    output logic                             rxSerialBit,
    output logic                             txSectionRun,
    output logic                             rxSectionRun,
    output logic [3:0]                       modemSeen,
    output logic                             tx_level_irq,
    output logic                             rx_level_irq,
    output logic                             irqOut
);
    import uic_pkg::*;

    uic_ctrl_type          ctrl_ff;
    uic_level_type         lvl_ff;
    uic_enc_type           enc_ff;
    uic_enc_type           nxt_enc;
    logic [IRQ_BITS-1:0]   mask_ff;
    logic [IRQ_BITS-1:0]   raw_ff;
    logic [IRQ_BITS-1:0]   setVec;
    logic [IRQ_BITS-1:0]   clrVec;
    logic [IRQ_BITS-1:0]   masked;
    logic [1:0]            tick_ff;
    logic [LEVEL_W-1:0]    txPrev_ff;
    logic [LEVEL_W-1:0]    rxPrev_ff;
    logic [3:0]            modemPrev_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic                  irOut_ff;
    logic                  txLine_ff;
    logic                  rxBit_ff;
    logic                  txRun_ff;
    logic                  rxRun_ff;
    logic [3:0]            modem_ff;
    logic                  txIrq_ff;
    logic                  rxIrq_ff;
    logic                  irq_ff;

    wire        setupPh  = psel & ~penable;
    wire        accessOk = psel & penable & pready_ff;
    wire        wrDone   = accessOk & pwrite;
    wire        hitCtrl  = paddr == OFS_CTRL;
    wire        hitLvl   = paddr == OFS_LVL;
    wire        hitMask  = paddr == OFS_MASK;
    wire        hitRaw   = paddr == OFS_RAW;
    wire        hitMstat = paddr == OFS_MSTAT;
    wire        hitClr   = paddr == OFS_CLR;
    wire        mapped   = hitCtrl | hitLvl | hitMask | hitRaw | hitMstat | hitClr;
    // finish character: the running character keeps its section alive.
    wire        liveEn   = ctrl_ff.en | txCharBusy | rxCharBusy;
    // gated enable: the codec only counts while the UART is enabled or a character is still running.
    wire        sirOn    = ctrl_ff.ir_codec_enable & liveEn;
    wire        refTick  = ctrl_ff.lowPower ? ir_low_power_ref_clk : baud16Tick;
    wire        lastTick = refTick & (tick_ff == PULSE_TICKS - 2'h1);
    wire [LEVEL_W-1:0] txTrig = trigPoint(lvl_ff.txSel);
    wire [LEVEL_W-1:0] rxTrig = trigPoint(lvl_ff.rxSel);
    // crossing only: the trigger needs the previous level on the other side.
    wire        txCross  = (txPrev_ff > txTrig) & (txFifoLevel <= txTrig);
    wire        rxCross  = (rxPrev_ff < rxTrig) & (rxFifoLevel >= rxTrig);
    // modem ignored: no change is flagged while the codec runs; the held previous value is compared once it stops.
    wire [3:0]  modemChg = (modemIn ^ modemPrev_ff) & {4{~sirOn}};
    // masked status: raw state gated by the mask.
    assign masked = raw_ff & mask_ff;

    always_comb begin
        setVec                               = '0;
        setVec[IRQ_OVR:IRQ_FRM]              = lineErrEvt;
        setVec[IRQ_RTO]                      = rxTimeoutEvt;
        setVec[IRQ_TXL]                      = txCross;
        setVec[IRQ_RXL]                      = rxCross;
        setVec[3:0]                          = modemChg;
        // clear on one: zeros in the written word leave bits alone.
        clrVec                               = (wrDone & hitClr) ? pwdata[IRQ_BITS-1:0] : '0;
    end

    // reserved zero: only defined fields reach the read mux.
    wire [31:0] rdMux =
        hitCtrl  ? {22'h0, ctrl_ff.receive_section_enable, ctrl_ff.transmit_section_enable, 5'h0, ctrl_ff.lowPower,
                    ctrl_ff.ir_codec_enable, ctrl_ff.en} :
        hitLvl   ? {26'h0, lvl_ff.rxSel, lvl_ff.txSel} :
        hitMask  ? {21'h0, mask_ff} :
        hitRaw   ? {21'h0, raw_ff} :
        hitMstat ? {21'h0, masked} : 32'h0000_0000;

    // Answer in the first access cycle; if the clock enable is low at the end of setup, pready never rises.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (ce) begin
            pready_ff  <= setupPh;
            pslverr_ff <= setupPh & ~mapped;
            prdata_ff  <= (setupPh & ~pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff <= '0;
            // half-full reset: both trigger codes start at the midpoint.
            lvl_ff  <= '{rxSel: LVL_HALF, txSel: LVL_HALF};
            // mask reset: every source starts masked off.
            mask_ff <= '0;
        end else if (ce & wrDone) begin
            if (hitCtrl) begin
                ctrl_ff <= '{receive_section_enable: pwdata[CTL_RXE], transmit_section_enable: pwdata[CTL_TXE],
                             lowPower: pwdata[CTL_LP], ir_codec_enable: pwdata[CTL_SIR],
                             en: pwdata[CTL_EN]};
            end
            if (hitLvl) begin
                lvl_ff <= '{rxSel: pwdata[LVL_RX_LO+:3], txSel: pwdata[LVL_TX_LO+:3]};
            end
            // mask write: ones set and zeros clear, layout kept.
            if (hitMask) begin
                mask_ff <= pwdata[IRQ_BITS-1:0];
            end
        end
    end

    // One sticky status bit per source; a set in the clearing cycle wins.
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_BITS; gi++) begin : g_stat
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    raw_ff[gi] <= 1'b0;
                end else if (ce) begin
                    raw_ff[gi] <= setVec[gi] | (raw_ff[gi] & ~clrVec[gi]);
                end
            end
        end
    endgenerate

    // pulse timing: three ticks of the selected reference end the pulse.
    always_comb begin
        case (enc_ff)
            ENC_IDLE: begin
                nxt_enc = (sirOn & txBitStart & ~txSerialBit) ? ENC_PULSE : ENC_IDLE;
            end
            ENC_PULSE: begin
                nxt_enc = (lastTick | ~sirOn) ? ENC_IDLE : ENC_PULSE;
            end
            default: begin
                nxt_enc = ENC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enc_ff  <= ENC_IDLE;
            tick_ff <= 2'h0;
        end else if (ce) begin
            enc_ff  <= nxt_enc;
            tick_ff <= (enc_ff == ENC_PULSE && refTick) ? tick_ff + 2'h1 :
                       (enc_ff == ENC_PULSE) ? tick_ff : 2'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irOut_ff     <= 1'b0;
            txLine_ff    <= 1'b1;
            rxBit_ff     <= 1'b1;
            txRun_ff     <= 1'b0;
            rxRun_ff     <= 1'b0;
            modem_ff     <= 4'h0;
            modemPrev_ff <= 4'h0;
            txPrev_ff    <= '0;
            rxPrev_ff    <= '0;
            txIrq_ff     <= 1'b0;
            rxIrq_ff     <= 1'b0;
            irq_ff       <= 1'b0;
        end else if (ce) begin
            // dark when off: the IR output only pulses while the codec runs.
            irOut_ff     <= sirOn & (nxt_enc == ENC_PULSE);
            // marking line: the wired output idles high under IR mode.
            txLine_ff    <= sirOn | txSerialBit;
            rxBit_ff     <= sirOn ? ~ir_pulse_in : wired_rx_line;
            // section gating: each direction needs its own enable and the global one, or its character still running.
            txRun_ff     <= (ctrl_ff.transmit_section_enable & ctrl_ff.en) | txCharBusy;
            rxRun_ff     <= (ctrl_ff.receive_section_enable & ctrl_ff.en) | rxCharBusy;
            modem_ff     <= sirOn ? modem_ff : modemIn;
            modemPrev_ff <= sirOn ? modemPrev_ff : modemIn;
            txPrev_ff    <= txFifoLevel;
            rxPrev_ff    <= rxFifoLevel;
            txIrq_ff     <= masked[IRQ_TXL];
            rxIrq_ff     <= masked[IRQ_RXL];
            // combined line: any masked source raises it.
            irq_ff       <= |masked;
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign ir_pulse_out_n = irOut_ff;
    assign wired_tx_line  = txLine_ff;
    assign rxSerialBit    = rxBit_ff;
    assign txSectionRun   = txRun_ff;
    assign rxSectionRun   = rxRun_ff;
    assign modemSeen      = modem_ff;
    assign tx_level_irq   = txIrq_ff;
    assign rx_level_irq   = rxIrq_ff;
    assign irqOut         = irq_ff;

    // Frozen cycles are skipped, since no state moves while the enable is low.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst || !ce);

    sequence pulseEnds;
        (enc_ff == ENC_PULSE) && lastTick && sirOn;
    endsequence

    sequence encIdleNext;
        ##1 (enc_ff == ENC_IDLE);
    endsequence

    sequence pulseStarts;
        (enc_ff == ENC_IDLE) && sirOn && txBitStart && !txSerialBit;
    endsequence

    sequence maskWrite;
        wrDone && hitMask;
    endsequence

    sequence clrWrite;
        wrDone && hitClr;
    endsequence

    AST_PULSE_END: assert property (pulseEnds |-> encIdleNext)
        else $error("IR pulse did not end after three reference ticks.");

    AST_PULSE_HOLD: assert property ((enc_ff == ENC_PULSE) && sirOn && !refTick
                                     |=> enc_ff == ENC_PULSE)
        else $error("IR pulse ended without a reference tick.");

    AST_SIR_GATED: assert property (!ctrl_ff.en && !txCharBusy && !rxCharBusy
                                    |=> !ir_pulse_out_n && wired_tx_line == $past(txSerialBit))
        else $error("IR codec active while the UART is disabled.");

    AST_WIRED_MARK: assert property (sirOn |=> wired_tx_line)
        else $error("Wired transmit line left marking state in IR mode.");

    AST_IR_DARK: assert property (!sirOn |=> !ir_pulse_out_n)
        else $error("IR output pulsed while the codec was off.");

    AST_FINISH_CHAR: assert property (txCharBusy |=> txSectionRun)
        else $error("Transmit section stopped mid character.");

    AST_TX_GATE: assert property (!ctrl_ff.en && !txCharBusy |=> !txSectionRun)
        else $error("Transmit section ran without the global enable.");

    AST_RX_GATE: assert property (ctrl_ff.receive_section_enable && ctrl_ff.en |=> rxSectionRun)
        else $error("Receive section idle with both enables set.");

    AST_RX_EDGE: assert property (rxCross |-> rxPrev_ff < rxFifoLevel)
        else $error("Receive trigger fired without a rising level.");

    AST_LVL_RESET: assert property ($past(rst) |-> lvl_ff.rxSel == LVL_HALF
                                    && lvl_ff.txSel == LVL_HALF)
        else $error("Trigger levels not at half full after reset.");

    AST_MASK_RESET: assert property ($past(rst) |-> mask_ff == '0)
        else $error("Mask not cleared by reset.");

    AST_RSVD_ZERO: assert property (pready_ff |-> prdata_ff[31:11] == 21'h0
                                    && (!hitCtrl || prdata_ff[6:3] == 4'h0)
                                    && (!hitLvl || prdata_ff[10:6] == 5'h0))
        else $error("Reserved read bits not zero.");

    AST_SET_WINS: assert property (setVec[IRQ_RXL] |=> raw_ff[IRQ_RXL])
        else $error("Status event lost against a clear.");

    AST_IRQ_LINE: assert property ((|masked) |=> irqOut)
        else $error("Combined interrupt missing for a masked source.");

    AST_IRQ_QUIET: assert property (!(|masked) ##1 !(|masked) |-> !irqOut)
        else $error("Combined interrupt high with nothing pending.");

    AST_PULSE_START: assert property (pulseStarts |=> ir_pulse_out_n)
        else $error("IR pulse missing for a zero bit.");

    AST_MASK_SET: assert property (maskWrite ##0 pwdata[IRQ_OVR] |=> mask_ff[IRQ_OVR])
        else $error("Mask bit not set by a one.");

    AST_MASK_CLEAR: assert property (maskWrite ##0 !pwdata[IRQ_OVR] |=> !mask_ff[IRQ_OVR])
        else $error("Mask bit not cleared by a zero.");

    AST_CLR_ONE: assert property (clrWrite ##0 pwdata[IRQ_OVR] && !setVec[IRQ_OVR]
                                  |=> !raw_ff[IRQ_OVR])
        else $error("Status bit not cleared by a one.");

    AST_CLR_ZERO: assert property (clrWrite ##0 !pwdata[IRQ_FRM] && raw_ff[IRQ_FRM]
                                   |=> raw_ff[IRQ_FRM])
        else $error("Status bit cleared by a zero.");

    AST_TX_EDGE: assert property (txCross |-> txPrev_ff > txFifoLevel)
        else $error("Transmit trigger fired without a falling level.");

    AST_NO_REFIRE: assert property (rxFifoLevel == rxPrev_ff |-> !rxCross)
        else $error("Receive trigger fired on a steady level.");

    AST_TX_STEADY: assert property (txFifoLevel == txPrev_ff |-> !txCross)
        else $error("Transmit trigger fired on a steady level.");

    AST_MODEM_HOLD: assert property (sirOn |=> $stable(modemSeen))
        else $error("Modem inputs seen in IR mode.");

    AST_IR_RX: assert property (sirOn |=> rxSerialBit == !$past(ir_pulse_in))
        else $error("Receive bit not taken from the IR input.");

    AST_WIRED_RX: assert property (!sirOn |=> rxSerialBit == $past(wired_rx_line))
        else $error("Receive bit not taken from the wired line.");

    AST_TX_IRQ: assert property (masked[IRQ_TXL] |=> tx_level_irq)
        else $error("Transmit level interrupt missing.");

    AST_RX_IRQ: assert property (!masked[IRQ_RXL] |=> !rx_level_irq)
        else $error("Receive level interrupt without masked status.");

endmodule // uic_core

/* test/uic_far_model.sv */
// Far-side model: remote serial device and infrared transceiver.
// Assumes one clock; noisy makes every line keep changing, else irIn and rxLine rest idle and modem holds.
module uic_far_model (
    input  wire logic       clk_sys,
    input  wire logic       noisy,
    output logic            irIn,
    output logic            rxLine,
    output logic [3:0]      modem
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ph;
    initial begin
        ph = 1'h0;
        irIn = 1'h0;
        rxLine = 1'h1;
        modem = 4'h0;
    end
    // The wired line toggles at half the rate so the two paths can be told apart.
    always @(posedge clk_sys) begin
        ph <= ~ph;
        if (noisy) begin
            irIn <= ~irIn;
            modem <= ~modem;
            if (ph) begin
                rxLine <= ~rxLine;
            end
        end else begin
            irIn <= 1'h0;
            rxLine <= 1'h1;
        end
    end
endmodule // uic_far_model

/* test/uic_core_bench.sv */
// Self-checking bench for the UART control, IR codec and interrupt block.
// Assumes the far-side model drives the wired, infrared and modem inputs.
module uic_core_bench;
    import uic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk_sys, rst, psel, penable, pwrite, pready, pslverr, lastErr;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               txSerialBit, txBitStart, baud16Tick, lpTick, noisy, lastIn;
    logic               txCharBusy, rxCharBusy, rxTimeoutEvt, irOut, wiredTx, rxSerialBit;
    logic               txRun, rxRun, txIrq, rxIrq, irqOut, irIn, rxLine;
    logic [3:0]         lineErrEvt, modem, modemSeen, seenHold;
    logic [LEVEL_W-1:0] txLvl, rxLvl;
    int                 errors, n_compared;

    uic_far_model far (.clk_sys(clk_sys), .noisy(noisy), .irIn(irIn), .rxLine(rxLine),
        .modem(modem));
    uic_core uut (.clk_sys(clk_sys), .rst(rst), .ce(1'h1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txSerialBit(txSerialBit), .txBitStart(txBitStart),
        .baud16Tick(baud16Tick), .ir_low_power_ref_clk(lpTick), .txCharBusy(txCharBusy),
        .rxCharBusy(rxCharBusy), .wired_rx_line(rxLine), .ir_pulse_in(irIn),
        .modemIn(modem), .lineErrEvt(lineErrEvt), .rxTimeoutEvt(rxTimeoutEvt),
        .txFifoLevel(txLvl), .rxFifoLevel(rxLvl), .ir_pulse_out_n(irOut),
        .wired_tx_line(wiredTx), .rxSerialBit(rxSerialBit), .txSectionRun(txRun),
        .rxSectionRun(rxRun), .modemSeen(modemSeen), .tx_level_irq(txIrq),
        .rx_level_irq(rxIrq), .irqOut(irqOut));

    task automatic report_and_stop();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // The request stands until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0000_0000);
        cmp(what, exp, rd);
    endtask

    task automatic tick(input logic lp);
        @(posedge clk_sys);
        lpTick <= lp;
        baud16Tick <= ~lp;
        @(posedge clk_sys);
        lpTick <= 1'h0;
        baud16Tick <= 1'h0;
        #1;
    endtask

    task automatic setLvl(input int r, input int t);
        @(posedge clk_sys);
        rxLvl <= LEVEL_W'(r);
        txLvl <= LEVEL_W'(t);
        cycles(2);
    endtask

    task automatic chkRx(input logic ir);
        repeat (3) begin
            @(posedge clk_sys);
            lastIn = ir ? ~irIn : rxLine;
            #1;
            cmp("rx path", 32'(lastIn), 32'(rxSerialBit));
        end
    endtask

    task automatic t_regs();
        rdc("ctrl rst", OFS_CTRL, 32'h0000_0000);
        rdc("level rst", OFS_LVL, 32'h0000_0012);
        rdc("mask rst", OFS_MASK, 32'h0000_0000);
        wr(OFS_MASK, 32'hFFFF_FFFF);
        rdc("mask all", OFS_MASK, 32'h0000_07FF);
        wr(OFS_MASK, 32'h0000_0000);
        rdc("mask clr", OFS_MASK, 32'h0000_0000);
        wr(OFS_LVL, 32'hFFFF_FFFF);
        rdc("level rsv", OFS_LVL, 32'h0000_003F);
        wr(OFS_CTRL, 32'hFFFF_FFFF);
        rdc("ctrl rsv", OFS_CTRL, 32'h0000_0307);
        wr(OFS_CTRL, 32'h0000_0000);
        apb(1'h0, 12'hFF0, 32'h0000_0000);
        cmp("unmapped err", 32'h1, 32'(lastErr));
        cmp("unmapped rd", 32'h0, rd);
    endtask

    task automatic t_irq();
        wr(OFS_MASK, 32'h0000_0400);
        @(posedge clk_sys);
        lineErrEvt <= 4'h9;
        rxTimeoutEvt <= 1'h1;
        @(posedge clk_sys);
        lineErrEvt <= 4'h0;
        rxTimeoutEvt <= 1'h0;
        cycles(3);
        cmp("irq set", 32'h1, 32'(irqOut));
        rdc("raw", OFS_RAW, 32'h0000_04C0);
        rdc("masked", OFS_MSTAT, 32'h0000_0400);
        wr(OFS_CLR, 32'h0000_0400);
        cycles(2);
        cmp("irq clr", 32'h0, 32'(irqOut));
        rdc("raw left", OFS_RAW, 32'h0000_00C0);
        wr(OFS_MASK, 32'h0000_0080);
        cycles(2);
        cmp("irq unmask", 32'h1, 32'(irqOut));
        wr(OFS_CLR, 32'h0000_00C0);
    endtask

    task automatic t_levels();
        int pt;
        int frac[5] = '{1, 2, 4, 6, 7};
        wr(OFS_MASK, 32'h0000_0030);
        for (int k = 0; k < 5; k++) begin
            pt = FIFO_DEPTH * frac[k] / 8;
            wr(OFS_LVL, 32'(k * 9));
            wr(OFS_CLR, 32'h0000_0030);
            setLvl(pt - 1, pt + 1);
            cmp("rx below", 32'h0, 32'(rxIrq));
            cmp("tx above", 32'h0, 32'(txIrq));
            setLvl(pt, pt);
            cmp("rx trig", 32'h1, 32'(rxIrq));
            cmp("tx trig", 32'h1, 32'(txIrq));
            wr(OFS_CLR, 32'h0000_0030);
            cycles(2);
            cmp("no retrig", 32'h0, 32'(rxIrq | txIrq));
        end
    endtask

    task automatic t_ir();
        for (int lp = 0; lp < 2; lp++) begin
            wr(OFS_CTRL, 32'h0000_0000);
            cycles(2);
            wr(OFS_CTRL, 32'(32'h103 | (lp << 2)));
            @(posedge clk_sys);
            txSerialBit <= 1'h0;
            txBitStart <= 1'h1;
            @(posedge clk_sys);
            txBitStart <= 1'h0;
            cycles(2);
            cmp("ir start", 32'h1, 32'(irOut));
            cmp("wired mark", 32'h1, 32'(wiredTx));
            repeat (3) tick(lp == 0);
            repeat (2) tick(lp == 1);
            cmp("ir held", 32'h1, 32'(irOut));
            tick(lp == 1);
            cycles(3);
            cmp("ir end", 32'h0, 32'(irOut));
        end
    endtask

    task automatic t_mode();
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0002);
        @(posedge clk_sys);
        noisy <= 1'h1;
        txSerialBit <= 1'h0;
        cycles(3);
        cmp("wired no en", 32'h0, 32'(wiredTx));
        cmp("ir no en", 32'h0, 32'(irOut));
        chkRx(1'h0);
        wr(OFS_CTRL, 32'h0000_0003);
        cycles(2);
        cmp("wired ir", 32'h1, 32'(wiredTx));
        chkRx(1'h1);
        seenHold = modemSeen;
        cycles(3);
        cmp("modem frozen", 32'(seenHold), 32'(modemSeen));
        wr(OFS_CLR, 32'h0000_000F);
        rdc("modem ignored", OFS_RAW, 32'h0000_0000);
        @(posedge clk_sys);
        noisy <= 1'h0;
        txSerialBit <= 1'h1;
        wr(OFS_CTRL, 32'h0000_0000);
    endtask

    task automatic t_sect();
        wr(OFS_CTRL, 32'h0000_0300);
        cycles(2);
        cmp("tx no en", 32'h0, 32'(txRun));
        cmp("rx no en", 32'h0, 32'(rxRun));
        wr(OFS_CTRL, 32'h0000_0101);
        cycles(2);
        cmp("tx on", 32'h1, 32'(txRun));
        cmp("rx off", 32'h0, 32'(rxRun));
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0301);
        @(posedge clk_sys);
        txCharBusy <= 1'h1;
        rxCharBusy <= 1'h1;
        wr(OFS_CTRL, 32'h0000_0000);
        cycles(2);
        cmp("tx finish", 32'h1, 32'(txRun));
        cmp("rx finish", 32'h1, 32'(rxRun));
        @(posedge clk_sys);
        txCharBusy <= 1'h0;
        rxCharBusy <= 1'h0;
        cycles(2);
        cmp("tx halt", 32'h0, 32'(txRun));
        cmp("rx halt", 32'h0, 32'(rxRun));
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    // The whole run needs well under a millisecond of simulated time.
    initial begin
        #3000000;
        errors++;
        report_and_stop();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {txBitStart, baud16Tick, lpTick, noisy, txCharBusy, rxCharBusy} = '0;
        {rxTimeoutEvt, lineErrEvt, txLvl, rxLvl} = '0;
        txSerialBit = 1'h1;
        rst = 1'h1;
        errors = 0;
        n_compared = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        t_regs();
        t_irq();
        t_levels();
        t_ir();
        t_mode();
        t_sect();
        report_and_stop();
    end
endmodule // uic_core_bench
